// ### rtl/cfx_exec.sv
// Execution of condition-code logic, mask setting, stack adjust,
// extension and multi-register load and store.
// Assumes one instruction offered at a time with start_in while busy_out low,
// and a data memory that answers each access with mem_ready_in.
//
// Behaviour
// - OR immediate into condition code byte
// - Flag logic 1 cycle, 2 if next uses stack
// - Mask set uses immediate bits 4 to 0
// - High mask forces new mask into 16..31
// - Low mask accepts any value unchanged
// - Stack adjust adds sign-extended immediate times four
// - Sign extend low byte or half-word
// - Zero extend low byte or half-word
// - Data flags unchanged; extension, mask one cycle
// - Load ascending, read then add four
// - Store descending, subtract four then write
// - Low load bit n selects register n
// - High load bit n selects register 8+n
// - Low store list bits map reversed
// - High store reversed, bit 0 is 15
// - Loaded stack pointer keeps memory word
// - Stored stack pointer is pre-instruction value
// - Load cycles a(n-1)+b+1, empty list one
// - Store cycles a times n plus one
// - Memory waits stretch; load-use adds interlock
`timescale 1ns/1ps
`include "cfx_defines.svh"
module cfx_exec (
  input  wire logic             clock_in,
  input  wire logic             nrst_in,
  input  wire logic             start_in,
  input  wire cfx_pkg::cfx_op_e op_in,
  input  wire logic [7:0]       imm_in,
  input  wire logic [3:0]       reg_sel_in,
  input  wire logic             next_uses_sp_in,
  input  wire logic             next_uses_load_in,
  input  wire logic             mem_ready_in,
  input  wire logic [31:0]      mem_rdata_in,
  input  wire logic [3:0]       gpr_rd_idx_in,
  output logic      [31:0]      gpr_rd_data_out,
  output logic                  busy_out,
  output logic                  done_out,
  output logic                  mem_req_out,
  output logic                  mem_we_out,
  output logic      [31:0]      mem_addr_out,
  output logic      [31:0]      mem_wdata_out,
  output logic      [7:0]       condition_code_byte_out,
  output logic      [4:0]       interrupt_level_mask_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]         gpr_reg [`CFX_GPR_COUNT];
  logic [31:0]         gpr_next [`CFX_GPR_COUNT];
  logic [7:0]          ccr_reg, ccr_next;
  logic [4:0]          ilm_reg, ilm_next;
  cfx_pkg::cfx_state_e state_reg, state_next;
  logic [15:0]         pend_reg, pend_next;
  logic                load_reg, load_next;
  logic                lock_reg, lock_next;
  logic                done_reg, done_next;
  logic [31:0]         sp_orig_reg, sp_orig_next;
  logic [3:0]          idx;
  logic                any;
  logic [15:0]         list16;
  logic [31:0]         ext_res;
  logic [31:0]         sp_adj;
  logic [31:0]         sp_dec;
  logic [4:0]          ilm_req;
  logic                is_ext;

  assign is_ext = (op_in == cfx_pkg::CFX_OP_SXB) || (op_in == cfx_pkg::CFX_OP_ZXB) ||
                  (op_in == cfx_pkg::CFX_OP_SXH) || (op_in == cfx_pkg::CFX_OP_ZXH);

  cfx_ext_unit cfx_ext_unit_inst (
    .src_in    (gpr_reg[reg_sel_in]),
    .half_in   ((op_in == cfx_pkg::CFX_OP_SXH) || (op_in == cfx_pkg::CFX_OP_ZXH)),
    .signed_in ((op_in == cfx_pkg::CFX_OP_SXB) || (op_in == cfx_pkg::CFX_OP_SXH)),
    .res_out   (ext_res)
  );

  cfx_list_pick cfx_list_pick_inst (
    .set_in    (pend_reg),
    .ascend_in (load_reg),
    .idx_out   (idx),
    .any_out   (any)
  );

  // Decode list into a 16-bit register set
  always_comb
  begin
    list16 = 16'h0000;
    for (int i = 0; i < 8; i++)
    begin
      unique case (op_in)
        cfx_pkg::CFX_OP_LDLO: list16[i]     = imm_in[i];
        cfx_pkg::CFX_OP_LDHI: list16[8 + i] = imm_in[i];
        cfx_pkg::CFX_OP_STLO: list16[7 - i] = imm_in[i];
        cfx_pkg::CFX_OP_STHI: list16[15 - i] = imm_in[i];
        default:              ;
      endcase
    end
  end

  assign sp_adj  = gpr_reg[`CFX_SP_INDEX] + {{22{imm_in[7]}}, imm_in, 2'b00};
  assign ilm_req = imm_in[`CFX_ILM_HIGH_BIT:0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    for (int r = 0; r < `CFX_GPR_COUNT; r++)
      gpr_next[r] = gpr_reg[r];
    ccr_next     = ccr_reg;
    ilm_next     = ilm_reg;
    state_next   = state_reg;
    pend_next    = pend_reg;
    load_next    = load_reg;
    lock_next    = 1'b0;
    done_next    = 1'b0;
    sp_orig_next = sp_orig_reg;
    unique case (state_reg)
      cfx_pkg::CFX_ST_IDLE:
      begin
        // Interlock cycle refuses a new instruction
        if (start_in && !lock_reg)
        begin
          unique case (op_in)
            cfx_pkg::CFX_OP_ANDCC:
            begin
              ccr_next  = ccr_reg & imm_in;
              lock_next = next_uses_sp_in;
            end
            cfx_pkg::CFX_OP_ORCC:
            begin
              ccr_next  = ccr_reg | imm_in;
              lock_next = next_uses_sp_in;
            end
            cfx_pkg::CFX_OP_SETIM:
            begin
              if (ilm_reg[`CFX_ILM_HIGH_BIT] && !ilm_req[`CFX_ILM_HIGH_BIT])
                ilm_next = ilm_req + `CFX_ILM_HIGH_ADD;
              else
                ilm_next = ilm_req;
            end
            cfx_pkg::CFX_OP_ADJSP: gpr_next[`CFX_SP_INDEX] = sp_adj;
            cfx_pkg::CFX_OP_LDLO, cfx_pkg::CFX_OP_LDHI,
            cfx_pkg::CFX_OP_STLO, cfx_pkg::CFX_OP_STHI:
            begin
              // Empty list finishes here without touching memory
              if (|list16)
              begin
                pend_next    = list16;
                load_next    = (op_in == cfx_pkg::CFX_OP_LDLO) ||
                               (op_in == cfx_pkg::CFX_OP_LDHI);
                sp_orig_next = gpr_reg[`CFX_SP_INDEX];
                state_next   = cfx_pkg::CFX_ST_MEM;
              end
            end
            default:
            begin
              if (is_ext)
                gpr_next[reg_sel_in] = ext_res;
            end
          endcase
        end
      end
      cfx_pkg::CFX_ST_MEM:
      begin
        // Request stands every cycle; ready stretches each word
        if (mem_ready_in)
        begin
          pend_next = pend_reg & ~(16'h0001 << idx);
          if (load_reg)
          begin
            gpr_next[`CFX_SP_INDEX] = gpr_reg[`CFX_SP_INDEX] + `CFX_WORD_STEP;
            gpr_next[idx]           = mem_rdata_in;
          end
          else
            gpr_next[`CFX_SP_INDEX] = sp_dec;
          if (pend_next == 16'h0000)
          begin
            // No trailing state, so the counts stay exact
            state_next = cfx_pkg::CFX_ST_IDLE;
            done_next  = 1'b1;
            lock_next  = load_reg && next_uses_load_in;
          end
        end
      end
      default:              state_next = cfx_pkg::CFX_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      for (int r = 0; r < `CFX_GPR_COUNT; r++)
        gpr_reg[r] <= `CFX_SP_RESET;
      ccr_reg     <= `CFX_CCR_RESET;
      ilm_reg     <= `CFX_ILM_RESET;
      state_reg   <= cfx_pkg::CFX_ST_IDLE;
      pend_reg    <= 16'h0000;
      load_reg    <= 1'b0;
      lock_reg    <= 1'b0;
      done_reg    <= 1'b0;
      sp_orig_reg <= `CFX_SP_RESET;
    end
    else
    begin
      for (int r = 0; r < `CFX_GPR_COUNT; r++)
        gpr_reg[r] <= gpr_next[r];
      ccr_reg     <= ccr_next;
      ilm_reg     <= ilm_next;
      state_reg   <= state_next;
      pend_reg    <= pend_next;
      load_reg    <= load_next;
      lock_reg    <= lock_next;
      done_reg    <= done_next;
      sp_orig_reg <= sp_orig_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Store addresses the decremented pointer; it only commits on ready
  assign sp_dec        = gpr_reg[`CFX_SP_INDEX] - `CFX_WORD_STEP;
  assign busy_out      = (state_reg != cfx_pkg::CFX_ST_IDLE) || lock_reg;
  assign done_out      = done_reg;
  assign mem_req_out   = (state_reg == cfx_pkg::CFX_ST_MEM);
  assign mem_we_out    = mem_req_out && !load_reg;
  assign mem_addr_out  = load_reg ? gpr_reg[`CFX_SP_INDEX] : sp_dec;
  assign mem_wdata_out = (idx == `CFX_SP_INDEX) ? sp_orig_reg : gpr_reg[idx];
  assign gpr_rd_data_out          = gpr_reg[gpr_rd_idx_in];
  assign condition_code_byte_out  = ccr_reg;
  assign interrupt_level_mask_out = ilm_reg;

  ////////////////////////////////////////////////////////////////////////////
  a_and_ccr: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_IDLE && start_in && op_in == cfx_pkg::CFX_OP_ANDCC)
    |=> condition_code_byte_out == ($past(ccr_reg) & $past(imm_in)))
    else $error("and of condition byte wrong");
  a_or_ccr: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_IDLE && start_in && op_in == cfx_pkg::CFX_OP_ORCC)
    |=> condition_code_byte_out == ($past(ccr_reg) | $past(imm_in)))
    else $error("or of condition byte wrong");
  a_mask_high: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_IDLE && start_in && op_in == cfx_pkg::CFX_OP_SETIM
     && ilm_reg[4]) |=> interrupt_level_mask_out == {1'b1, $past(imm_in[3:0])})
    else $error("high mask not kept high");
  a_mask_low: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_IDLE && start_in && op_in == cfx_pkg::CFX_OP_SETIM
     && !ilm_reg[4]) |=> interrupt_level_mask_out == $past(imm_in[4:0]))
    else $error("low mask value altered");
  a_sp_adjust: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_IDLE && start_in && op_in == cfx_pkg::CFX_OP_ADJSP)
    |=> gpr_reg[15] == $past(gpr_reg[15]) + {{22{$past(imm_in[7])}}, $past(imm_in), 2'b00})
    else $error("stack adjust wrong");
  a_empty_list: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_IDLE && start_in && op_in >= cfx_pkg::CFX_OP_LDLO
     && imm_in == 8'h00) |=> (!mem_req_out && gpr_reg[15] == $past(gpr_reg[15])))
    else $error("empty list touched memory");
  a_ccr_lock: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_IDLE && start_in && !lock_reg && next_uses_sp_in &&
     (op_in == cfx_pkg::CFX_OP_ANDCC || op_in == cfx_pkg::CFX_OP_ORCC))
    |=> busy_out ##1 !busy_out)
    else $error("interlock cycle missing");
  a_store_addr: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_IDLE && start_in && !lock_reg && imm_in != 8'h00 &&
     (op_in == cfx_pkg::CFX_OP_STLO || op_in == cfx_pkg::CFX_OP_STHI))
    |=> mem_we_out && mem_addr_out == $past(gpr_reg[15]) - 32'h0000_0004)
    else $error("store address not predecremented");
  a_ext_byte: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_IDLE && start_in && !lock_reg &&
     op_in == cfx_pkg::CFX_OP_SXB) |=> gpr_reg[$past(reg_sel_in)] ==
    {{24{$past(gpr_reg[reg_sel_in][7])}}, $past(gpr_reg[reg_sel_in][7:0])})
    else $error("byte sign extension wrong");
  a_ext_half: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_IDLE && start_in && !lock_reg &&
     op_in == cfx_pkg::CFX_OP_ZXH) |=> gpr_reg[$past(reg_sel_in)] ==
    {16'h0000, $past(gpr_reg[reg_sel_in][15:0])})
    else $error("half-word zero extension wrong");
  a_load_data: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_MEM && load_reg && mem_ready_in)
    |=> gpr_reg[$past(idx)] == $past(mem_rdata_in))
    else $error("loaded word not written");
  a_load_step: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_MEM && load_reg && mem_ready_in && idx != 4'hF)
    |=> gpr_reg[15] == $past(gpr_reg[15]) + 32'h0000_0004)
    else $error("load pointer not advanced");
  a_store_step: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_MEM && !load_reg && mem_ready_in)
    |=> gpr_reg[15] == $past(gpr_reg[15]) - 32'h0000_0004)
    else $error("store pointer not lowered");
  // Stack pointer is the first word stored, so it is still untouched here
  a_store_sp: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_MEM && !load_reg && idx == 4'hF)
    |-> mem_wdata_out == gpr_reg[15])
    else $error("stored pointer not original");
  a_load_lock: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_reg == cfx_pkg::CFX_ST_MEM && load_reg && mem_ready_in && $onehot(pend_reg)
     && next_uses_load_in) |=> busy_out && state_reg == cfx_pkg::CFX_ST_IDLE)
    else $error("load-use interlock missing");
  a_req_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (mem_req_out && !mem_ready_in) |=> mem_req_out && $stable(mem_addr_out))
    else $error("access dropped before ready");
endmodule : cfx_exec

// ### pkg/cfx_defines.svh
// Constants for the flag, stack and multi-register execution group.
// Assumes inclusion by bare name from design files.
`ifndef CFX_DEFINES_SVH
`define CFX_DEFINES_SVH
`define CFX_CLK_PERIOD_NS   40
`define CFX_GPR_COUNT       16
`define CFX_SP_INDEX        4'hF
`define CFX_WORD_STEP       32'h0000_0004
`define CFX_ILM_WIDTH       5
`define CFX_ILM_HIGH_BIT    4
`define CFX_ILM_HIGH_ADD    5'h10
`define CFX_CCR_RESET       8'h00
`define CFX_ILM_RESET       5'h0F
`define CFX_SP_RESET        32'h0000_0000
`endif

// ### pkg/cfx_pkg.sv
// Types for the flag, stack and multi-register execution group.
// Assumes no surrounding context.
package cfx_pkg;
  typedef enum logic [3:0] {
    CFX_OP_NONE  = 4'h0,
    CFX_OP_ANDCC = 4'h1,
    CFX_OP_ORCC  = 4'h2,
    CFX_OP_SETIM = 4'h3,
    CFX_OP_ADJSP = 4'h4,
    CFX_OP_SXB   = 4'h5,
    CFX_OP_ZXB   = 4'h6,
    CFX_OP_SXH   = 4'h7,
    CFX_OP_ZXH   = 4'h8,
    CFX_OP_LDLO  = 4'h9,
    CFX_OP_LDHI  = 4'hA,
    CFX_OP_STLO  = 4'hB,
    CFX_OP_STHI  = 4'hC
  } cfx_op_e;
  typedef enum logic [1:0] {
    CFX_ST_IDLE = 2'b00,
    CFX_ST_MEM  = 2'b01,
    CFX_ST_DONE = 2'b10
  } cfx_state_e;
endpackage : cfx_pkg

// ### rtl/cfx_ext_unit.sv
// Byte and half-word sign or zero extension.
// Assumes the selected register value arrives on src_in.
`timescale 1ns/1ps
module cfx_ext_unit (
  input  wire logic [31:0] src_in,
  input  wire logic        half_in,
  input  wire logic        signed_in,
  output logic      [31:0] res_out
);
  always_comb
  begin
    if (half_in)
      res_out = {{16{signed_in & src_in[15]}}, src_in[15:0]};
    else
      res_out = {{24{signed_in & src_in[7]}}, src_in[7:0]};
  end
endmodule : cfx_ext_unit

// ### rtl/cfx_list_pick.sv
// Picks the next register from a 16-bit selection set.
// Ascending picks the lowest set bit, otherwise the highest.
`timescale 1ns/1ps
module cfx_list_pick (
  input  wire logic [15:0] set_in,
  input  wire logic        ascend_in,
  output logic      [3:0]  idx_out,
  output logic             any_out
);
  always_comb
  begin
    idx_out = 4'h0;
    any_out = |set_in;
    if (ascend_in)
    begin
      for (int i = 15; i >= 0; i--)
        if (set_in[i])
          idx_out = 4'(i);
    end
    else
    begin
      for (int i = 0; i < 16; i++)
        if (set_in[i])
          idx_out = 4'(i);
    end
  end
endmodule : cfx_list_pick

// ### testbench/cfx_data_mem.sv
// Data memory model on the far side of the execution group.
// Assumes each access is held until the cycle after ready shows.
`timescale 1ns/1ps
module cfx_data_mem (
  input  wire logic        clock_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wait_in,
  output logic             ready_out,
  output logic      [31:0] rdata_out
);
  logic [31:0] words [0:63];
  logic [3:0]  cnt_reg;
  initial
  begin
    ready_out = 1'b0;
    rdata_out = 32'h0;
    cnt_reg = 4'h0;
    for (int k = 0; k < 64; k++)
      words[k] = 32'h0000_8080 + k;
  end
  // Read data scrambles outside ready so stale values never match
  always @(posedge clock_in)
  begin
    rdata_out <= ~rdata_out;
    ready_out <= 1'b0;
    if (req_in && !ready_out)
    begin
      if (cnt_reg == wait_in)
      begin
        cnt_reg <= 4'h0;
        ready_out <= 1'b1;
        rdata_out <= words[addr_in[7:2]];
        if (we_in)
          words[addr_in[7:2]] <= wdata_in;
      end
      else
        cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : cfx_data_mem

// ### testbench/cfx_exec_test.sv
// Self-checking bench for the execution group.
// Assumes the data memory model drives the far side.
`timescale 1ns/1ps
module cfx_exec_test;
  logic             clock_in, nrst_in, start_in, nsp, nld, rdy, busy, done, req, we, b1;
  cfx_pkg::cfx_op_e op;
  logic [7:0]       imm, condition_code_byte;
  logic [3:0]       sel, ridx, mwait;
  logic [4:0]       interrupt_level_mask;
  logic [31:0]      rdata, rd, addr, wdata;
  int               num_errors, n_tests, cyc, nreq, ndone, n0, nb, m0;
  ////////////////////////////////////////////////////////////////
  cfx_exec cfx_exec_inst (.clock_in(clock_in), .nrst_in(nrst_in), .start_in(start_in),
    .op_in(op), .imm_in(imm), .reg_sel_in(sel), .next_uses_sp_in(nsp),
    .next_uses_load_in(nld), .mem_ready_in(rdy), .mem_rdata_in(rdata),
    .gpr_rd_idx_in(ridx), .gpr_rd_data_out(rd), .busy_out(busy), .done_out(done),
    .mem_req_out(req), .mem_we_out(we), .mem_addr_out(addr), .mem_wdata_out(wdata),
    .condition_code_byte_out(condition_code_byte), .interrupt_level_mask_out(interrupt_level_mask));
  cfx_data_mem cfx_data_mem_inst (.clock_in(clock_in), .req_in(req), .we_in(we),
    .addr_in(addr), .wdata_in(wdata), .wait_in(mwait), .ready_out(rdy), .rdata_out(rdata));
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // Settled outputs are counted on the falling edge
  always @(negedge clock_in)
  begin
    cyc++;
    nreq += int'(req === 1'b1);
    ndone += int'(done === 1'b1);
    nb += int'(busy === 1'b1);
    if (cyc == 20000)
    begin
      num_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////
  task summarize;
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task issue(input cfx_pkg::cfx_op_e o, input logic [7:0] i, input logic [3:0] s,
             input logic n);
    int k;
    @(posedge clock_in);
    #2;
    op = o;
    imm = i;
    sel = s;
    nsp = n;
    start_in = 1'b1;
    @(posedge clock_in);
    #2;
    start_in = 1'b0;
    b1 = busy;
    k = 0;
    while (busy !== 1'b0 && k < 200)
    begin
      @(posedge clock_in);
      #2;
      k++;
    end
  endtask : issue
  task reg_is(input logic [3:0] idx, input logic [31:0] exp);
    @(posedge clock_in);
    #2;
    ridx = idx;
    #1;
    chk(rd, exp);
  endtask : reg_is
  ////////////////////////////////////////////////////////////////
  task t_flags;
    issue(cfx_pkg::CFX_OP_ORCC, 8'h3F, 4'h0, 1'b0);
    chk({24'h0, condition_code_byte}, 32'h3F);
    chk({31'h0, b1}, 32'h0);
    issue(cfx_pkg::CFX_OP_ANDCC, 8'hF0, 4'h0, 1'b1);
    chk({24'h0, condition_code_byte}, 32'h30);
    chk({31'h0, b1}, 32'h1);
  endtask : t_flags
  task t_mask;
    issue(cfx_pkg::CFX_OP_SETIM, 8'hE5, 4'h0, 1'b0);
    chk({27'h0, interrupt_level_mask}, 32'h05);
    issue(cfx_pkg::CFX_OP_SETIM, 8'h14, 4'h0, 1'b0);
    chk({27'h0, interrupt_level_mask}, 32'h14);
    issue(cfx_pkg::CFX_OP_SETIM, 8'h03, 4'h0, 1'b0);
    chk({27'h0, interrupt_level_mask}, 32'h13);
    issue(cfx_pkg::CFX_OP_SETIM, 8'h1A, 4'h0, 1'b0);
    chk({27'h0, interrupt_level_mask}, 32'h1A);
    chk({31'h0, b1}, 32'h0);
  endtask : t_mask
  task t_load;
    // Each model access lasts the wait count plus two cycles
    n0 = ndone;
    m0 = nb;
    issue(cfx_pkg::CFX_OP_LDLO, 8'hFF, 4'h0, 1'b0);
    chk(nb - m0, 32'h10);
    for (int k = 0; k < 8; k++)
      reg_is(k[3:0], 32'h8080 + k);
    reg_is(4'hF, 32'h20);
    mwait = 4'h2;
    m0 = nb;
    issue(cfx_pkg::CFX_OP_LDHI, 8'h7F, 4'h0, 1'b0);
    chk(nb - m0, 32'h1C);
    for (int k = 8; k < 15; k++)
      reg_is(k[3:0], 32'h8080 + k);
    reg_is(4'hF, 32'h3C);
    chk({24'h0, condition_code_byte}, 32'h30);
    chk(ndone, n0 + 2);
  endtask : t_load
  task t_ext;
    issue(cfx_pkg::CFX_OP_SXB, 8'h00, 4'h1, 1'b0);
    reg_is(4'h1, 32'hFFFF_FF81);
    chk({31'h0, b1}, 32'h0);
    issue(cfx_pkg::CFX_OP_ZXB, 8'h00, 4'h2, 1'b0);
    reg_is(4'h2, 32'h0000_0082);
    issue(cfx_pkg::CFX_OP_SXH, 8'h00, 4'h3, 1'b0);
    reg_is(4'h3, 32'hFFFF_8083);
    issue(cfx_pkg::CFX_OP_ZXH, 8'h00, 4'h4, 1'b0);
    reg_is(4'h4, 32'h0000_8084);
  endtask : t_ext
  task t_adjust;
    issue(cfx_pkg::CFX_OP_ADJSP, 8'hFF, 4'h0, 1'b0);
    reg_is(4'hF, 32'h38);
    issue(cfx_pkg::CFX_OP_ADJSP, 8'h02, 4'h0, 1'b0);
    reg_is(4'hF, 32'h40);
  endtask : t_adjust
  task t_store;
    mwait = 4'h1;
    m0 = nb;
    issue(cfx_pkg::CFX_OP_STLO, 8'h81, 4'h0, 1'b0);
    chk(nb - m0, 32'h06);
    chk(cfx_data_mem_inst.words[15], 32'h8087);
    chk(cfx_data_mem_inst.words[14], 32'h8080);
    reg_is(4'hF, 32'h38);
    m0 = nb;
    issue(cfx_pkg::CFX_OP_STHI, 8'h81, 4'h0, 1'b0);
    chk(nb - m0, 32'h06);
    chk(cfx_data_mem_inst.words[13], 32'h38);
    chk(cfx_data_mem_inst.words[12], 32'h8088);
    reg_is(4'hF, 32'h30);
    chk({24'h0, condition_code_byte}, 32'h30);
  endtask : t_store
  task t_empty;
    n0 = nreq;
    issue(cfx_pkg::CFX_OP_STLO, 8'h00, 4'h0, 1'b0);
    issue(cfx_pkg::CFX_OP_LDLO, 8'h00, 4'h0, 1'b0);
    chk({31'h0, b1}, 32'h0);
    chk(nreq, n0);
    reg_is(4'hF, 32'h30);
  endtask : t_empty
  task t_sp_load;
    issue(cfx_pkg::CFX_OP_LDHI, 8'h80, 4'h0, 1'b0);
    reg_is(4'hF, 32'h8088);
  endtask : t_sp_load
  task t_lock;
    mwait = 4'h1;
    nld = 1'b1;
    m0 = nb;
    issue(cfx_pkg::CFX_OP_LDLO, 8'h01, 4'h0, 1'b0);
    nld = 1'b0;
    chk(nb - m0, 32'h04);
    reg_is(4'h0, 32'h80A2);
  endtask : t_lock
  ////////////////////////////////////////////////////////////////
  initial
  begin
    nrst_in = 1'b0;
    start_in = 1'b0;
    op = cfx_pkg::CFX_OP_NONE;
    imm = 8'h00;
    sel = 4'h0;
    nsp = 1'b0;
    nld = 1'b0;
    ridx = 4'h0;
    mwait = 4'h0;
    repeat (12) @(posedge clock_in);
    #2;
    nrst_in = 1'b1;
    chk({24'h0, condition_code_byte}, 32'h00);
    chk({27'h0, interrupt_level_mask}, 32'h0F);
    t_flags();
    t_mask();
    t_load();
    t_ext();
    t_adjust();
    t_store();
    t_empty();
    t_sp_load();
    t_lock();
    summarize();
  end
endmodule : cfx_exec_test
